// ===== design/serial_break_wake_sync_master_tx.sv
// serial port: wake on receive edge, break send, synchronous master transmit
//
// Notes on behaviour
// - in sleep the baud generator halts, so no byte is received
// - wake enable set: normal reception stops, port idles watching the line
// - a falling edge on the receive line is the wake event
// - a wake event raises the receive interrupt flag
// - reading the receive buffer clears that flag; its content is dummy
// - first rising edge after the wake event clears wake enable
// - wake enable clearing does not depend on instruction clocks
// - a break is one start bit, twelve zeros and one stop bit
// - send break with transmit enable sends zeros, ignoring buffer data
// - hardware clears send break once the break stop bit has gone out
// - shift register empty bit behaves the same during a break
// - wake receive of a break takes two edges, then the next byte
// - clock source, sync mode and port enable select synchronous master
// - synchronous mode is half duplex
// - master drives shift clock; idle level follows clock polarity
// - shift register loads only after last bit, then sets transmit flag
// - transmit flag ignores its enable, clears by a buffer write or by clearing transmit enable
// - read-only shift register empty bit; shift register is hidden
// - words shift least significant bit first
`timescale 1ns/1ns
module serial_break_wake_sync_master_tx (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        sleep_mode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        data_line_in,
  output logic             data_line_out,
  output logic             data_line_oe,
  output logic             shift_clock_line_out,
  output logic             shift_clock_line_oe,
  output logic             receive_irq_flag,
  output logic             transmit_irq_flag
);

  typedef struct packed {
    logic [7:0]  txctl;
    logic [7:0]  rxctl;
    logic [7:0]  bdctl;
    logic [7:0]  div_hi;
    logic [7:0]  div_lo;
    logic [7:0]  tbuf;
    logic        tbuf_full;
    logic [7:0]  rbuf;
    logic        rx_flag;
    logic        woke;
    logic [2:0]  rx_sync;
    logic        rx_lvl;
    logic [15:0] baud_cnt;
    serial_port_pkg::tx_state_e tx_st;
    logic        tx_brk;
    logic [13:0] tx_sh;
    logic [3:0]  tx_left;
    logic        sclk_phase;
    logic        rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_slot;
    logic [7:0]  rx_sh;
    logic [31:0] rdata;
    logic        err;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        port_en;
  logic        sync_mode;
  logic        master;
  logic        tx_en;
  logic        wake_en;
  logic [15:0] divisor;
  logic        baud_tick;
  logic        rx_tick;
  logic        fall;
  logic        rise;
  logic        rx_on;
  logic        load;
  logic        bit9;
  logic        idle_sclk;
  logic [7:0]  tx_stat_rd;
  logic [7:0]  bauds_rd;

  assign port_en   = s_q.rxctl[serial_port_pkg::PORT_ENABLE_BIT];
  assign sync_mode = s_q.txctl[serial_port_pkg::SYNC_MODE_BIT];
  assign master    = sync_mode
                     & s_q.txctl[serial_port_pkg::CLOCK_SOURCE_SELECT_BIT]
                     & port_en;
  assign tx_en     = s_q.txctl[serial_port_pkg::TRANSMIT_ENABLE_BIT];
  assign wake_en   = s_q.bdctl[serial_port_pkg::WAKE_ENABLE_BIT];
  assign bit9      = s_q.txctl[serial_port_pkg::NINTH_BIT_TX_ENABLE_BIT];
  assign idle_sclk = s_q.bdctl[serial_port_pkg::CLOCK_POLARITY_BIT];
  assign divisor   = s_q.bdctl[serial_port_pkg::WIDE_BAUD_SELECT_BIT]
                     ? {s_q.div_hi, s_q.div_lo} : {8'h00, s_q.div_lo};

  // no clocks reach the baud generator while the chip sleeps
  assign baud_tick = (s_q.baud_cnt == 16'h0000) & ~sleep_mode;
  assign rx_tick   = (s_q.rx_cnt == 16'h0000) & ~sleep_mode;

  assign fall      = s_q.rx_lvl & ~s_q.rx_sync[1]
                     & (s_q.rx_sync[1] == s_q.rx_sync[2]);
  assign rise      = ~s_q.rx_lvl & s_q.rx_sync[1]
                     & (s_q.rx_sync[1] == s_q.rx_sync[2]);

  // the receiver only runs asynchronously and never while wake is armed
  assign rx_on     = port_en & ~sync_mode & ~wake_en & ~sleep_mode
                     & s_q.rxctl[serial_port_pkg::CONT_RECEIVE_BIT];

  assign load      = (s_q.tx_st == serial_port_pkg::TX_IDLE)
                     & s_q.tbuf_full & tx_en & port_en & ~sleep_mode;

  assign acc       = psel & penable & clk_en;
  assign wr        = acc & pwrite;
  assign rd        = acc & ~pwrite;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      serial_port_pkg::TX_STATUS_CONTROL_OFF,
      serial_port_pkg::RX_STATUS_CONTROL_OFF,
      serial_port_pkg::BAUD_CONTROL_OFF,
      serial_port_pkg::TRANSMIT_BUFFER_OFF,
      serial_port_pkg::RECEIVE_BUFFER_OFF,
      serial_port_pkg::BAUD_DIVISOR_HIGH_OFF,
      serial_port_pkg::BAUD_DIVISOR_LOW_OFF,
      serial_port_pkg::IRQ_FLAGS_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    tx_stat_rd = s_q.txctl;
    tx_stat_rd[serial_port_pkg::SHIFT_REG_EMPTY_BIT] =
      (s_q.tx_st == serial_port_pkg::TX_IDLE);
    bauds_rd = s_q.bdctl;
    bauds_rd[serial_port_pkg::RECEIVE_IDLE_STATUS_BIT] = ~s_q.rx_busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;

    // three stage pin sampler; a level counts once stages two and three agree
    s_d.rx_sync = {s_q.rx_sync[1:0], data_line_in};
    if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
      s_d.rx_lvl = s_q.rx_sync[2];
    end

    // bus: read data is prepared in the setup cycle
    if (psel & ~penable) begin
      s_d.err = ~mapped;
      s_d.rdata = 32'h0000_0000;
      unique case (paddr)
        serial_port_pkg::TX_STATUS_CONTROL_OFF: s_d.rdata[7:0] = tx_stat_rd;
        serial_port_pkg::RX_STATUS_CONTROL_OFF: s_d.rdata[7:0] = s_q.rxctl;
        serial_port_pkg::BAUD_CONTROL_OFF:      s_d.rdata[7:0] = bauds_rd;
        serial_port_pkg::TRANSMIT_BUFFER_OFF:   s_d.rdata[7:0] = s_q.tbuf;
        serial_port_pkg::RECEIVE_BUFFER_OFF:    s_d.rdata[7:0] = s_q.rbuf;
        serial_port_pkg::BAUD_DIVISOR_HIGH_OFF: s_d.rdata[7:0] = s_q.div_hi;
        serial_port_pkg::BAUD_DIVISOR_LOW_OFF:  s_d.rdata[7:0] = s_q.div_lo;
        serial_port_pkg::IRQ_FLAGS_OFF: begin
          s_d.rdata[serial_port_pkg::RECEIVE_IRQ_FLAG_BIT]  = s_q.rx_flag;
          s_d.rdata[serial_port_pkg::TRANSMIT_IRQ_FLAG_BIT] = transmit_irq_flag;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // reading the receive buffer drops the receive flag; any set below wins
    if (rd & (paddr == serial_port_pkg::RECEIVE_BUFFER_OFF)) begin
      s_d.rx_flag = 1'b0;
    end

    // shared baud counter: full bit period, or half period in sync master
    if (baud_tick) begin
      s_d.baud_cnt = master ? {1'b0, divisor[15:1]} : divisor;
    end else if (~sleep_mode) begin
      s_d.baud_cnt = s_q.baud_cnt - 16'h0001;
    end

    // transmitter
    unique case (s_q.tx_st)
      serial_port_pkg::TX_IDLE: begin
        if (load) begin
          s_d.tbuf_full = 1'b0;
          s_d.baud_cnt  = master ? {1'b0, divisor[15:1]} : divisor;
          s_d.sclk_phase = 1'b0;
          if (master) begin
            s_d.tx_st   = serial_port_pkg::TX_SYNC;
            s_d.tx_brk  = 1'b0;
            s_d.tx_sh   = {5'b11111,
              s_q.txctl[serial_port_pkg::NINTH_BIT_TX_VALUE_BIT], s_q.tbuf};
            s_d.tx_left = bit9 ? serial_port_pkg::SYNC_BITS_9
                               : serial_port_pkg::SYNC_BITS_8;
          end else if (s_q.txctl[serial_port_pkg::SEND_BREAK_BIT]) begin
            // buffer content is discarded, zeros go out
            s_d.tx_st   = serial_port_pkg::TX_ASYNC;
            s_d.tx_brk  = 1'b1;
            s_d.tx_sh   = serial_port_pkg::BREAK_FRAME;
            s_d.tx_left = serial_port_pkg::BREAK_BITS;
          end else begin
            s_d.tx_st   = serial_port_pkg::TX_ASYNC;
            s_d.tx_brk  = 1'b0;
            s_d.tx_sh   = {4'b1111,
              bit9 ? s_q.txctl[serial_port_pkg::NINTH_BIT_TX_VALUE_BIT]
                   : 1'b1, s_q.tbuf, 1'b0};
            s_d.tx_left = bit9 ? serial_port_pkg::ASYNC_BITS_9
                               : serial_port_pkg::ASYNC_BITS_8;
          end
        end
      end
      serial_port_pkg::TX_ASYNC: begin
        if (baud_tick) begin
          s_d.tx_sh   = {1'b1, s_q.tx_sh[13:1]};
          s_d.tx_left = s_q.tx_left - 4'h1;
          if (s_q.tx_left == 4'h1) begin
            s_d.tx_st = serial_port_pkg::TX_IDLE;
            if (s_q.tx_brk) begin
              s_d.txctl[serial_port_pkg::SEND_BREAK_BIT] = 1'b0;
            end
          end
        end
      end
      serial_port_pkg::TX_SYNC: begin
        // first half period clock leaves idle, second returns and shifts
        if (baud_tick) begin
          s_d.sclk_phase = ~s_q.sclk_phase;
          if (s_q.sclk_phase) begin
            s_d.tx_sh   = {1'b1, s_q.tx_sh[13:1]};
            s_d.tx_left = s_q.tx_left - 4'h1;
            if (s_q.tx_left == 4'h1) begin
              s_d.tx_st = serial_port_pkg::TX_IDLE;
            end
          end
        end
        if (~master) begin
          s_d.tx_st      = serial_port_pkg::TX_IDLE;
          s_d.sclk_phase = 1'b0;
        end
      end
      default: s_d.tx_st = serial_port_pkg::TX_IDLE;
    endcase

    // wake detection runs on the sampled pin only, no baud clock needed
    if (wake_en) begin
      s_d.rx_busy = 1'b0;
      if (fall & ~s_q.woke) begin
        s_d.woke = 1'b1;
      end else if (rise & s_q.woke) begin
        s_d.woke = 1'b0;
        s_d.bdctl[serial_port_pkg::WAKE_ENABLE_BIT] = 1'b0;
      end
    end else begin
      s_d.woke = 1'b0;
    end

    // asynchronous byte receiver, sampled mid bit
    if (~rx_on) begin
      s_d.rx_busy = 1'b0;
    end else if (~s_q.rx_busy) begin
      if (fall) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_slot = 4'h0;
        s_d.rx_cnt  = {1'b0, divisor[15:1]};
      end
    end else if (rx_tick) begin
      s_d.rx_cnt  = divisor;
      s_d.rx_slot = s_q.rx_slot + 4'h1;
      if (s_q.rx_slot == 4'h0) begin
        s_d.rx_busy = ~s_q.rx_lvl;
      end else if (s_q.rx_slot == serial_port_pkg::RX_STOP_SLOT) begin
        s_d.rx_busy = 1'b0;
        s_d.rbuf    = s_q.rx_sh;
        s_d.rx_flag = 1'b1;
      end else begin
        s_d.rx_sh   = {s_q.rx_lvl, s_q.rx_sh[7:1]};
      end
    end else begin
      s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
    end

    // register writes
    if (wr) begin
      unique case (paddr)
        serial_port_pkg::TX_STATUS_CONTROL_OFF: begin
          s_d.txctl = pwdata[7:0];
          s_d.txctl[serial_port_pkg::SHIFT_REG_EMPTY_BIT] = 1'b0;
        end
        serial_port_pkg::RX_STATUS_CONTROL_OFF: s_d.rxctl = pwdata[7:0];
        serial_port_pkg::BAUD_CONTROL_OFF: begin
          s_d.bdctl = pwdata[7:0];
          s_d.bdctl[serial_port_pkg::RECEIVE_IDLE_STATUS_BIT] = 1'b0;
        end
        serial_port_pkg::TRANSMIT_BUFFER_OFF: begin
          s_d.tbuf      = pwdata[7:0];
          s_d.tbuf_full = 1'b1;
        end
        serial_port_pkg::BAUD_DIVISOR_HIGH_OFF: s_d.div_hi = pwdata[7:0];
        serial_port_pkg::BAUD_DIVISOR_LOW_OFF:  s_d.div_lo = pwdata[7:0];
        default: s_d.err = s_q.err;
      endcase
    end

    // wake event flag, placed last so a set beats a same cycle clear
    if (wake_en & fall & ~s_q.woke) begin
      s_d.rx_flag = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.txctl    <= serial_port_pkg::CTRL_RESET;
      s_q.rxctl    <= serial_port_pkg::CTRL_RESET;
      s_q.bdctl    <= serial_port_pkg::CTRL_RESET;
      s_q.div_hi   <= serial_port_pkg::DIVISOR_RESET;
      s_q.div_lo   <= serial_port_pkg::DIVISOR_RESET;
      s_q.rx_sync  <= 3'b111;
      s_q.rx_lvl   <= 1'b1;
      s_q.tx_st    <= serial_port_pkg::TX_IDLE;
      s_q.tx_sh    <= 14'h3fff;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata  = s_q.rdata;
  assign pslverr = s_q.err;
  // clock enable low holds the access phase rather than losing it
  assign pready  = clk_en;

  assign receive_irq_flag  = s_q.rx_flag;
  // flag mirrors an empty buffer while transmit is enabled, regardless of any interrupt enable
  assign transmit_irq_flag = tx_en & ~s_q.tbuf_full;

  always_comb begin
    data_line_out        = 1'b1;
    data_line_oe         = 1'b0;
    shift_clock_line_out = idle_sclk;
    shift_clock_line_oe  = master;
    if (master) begin
      // half duplex: data is driven only while a word shifts out
      data_line_oe  = (s_q.tx_st == serial_port_pkg::TX_SYNC);
      data_line_out = s_q.tx_sh[0];
      shift_clock_line_out = idle_sclk ^ s_q.sclk_phase;
    end else if (port_en & ~sync_mode) begin
      data_line_oe  = 1'b1;
      data_line_out = (s_q.tx_st == serial_port_pkg::TX_ASYNC)
                      ? s_q.tx_sh[0] : 1'b1;
    end
  end

endmodule : serial_break_wake_sync_master_tx

// ===== design/serial_port_pkg.sv
// package: register map, field positions and state codes of the serial port
package serial_port_pkg;

  // register byte offsets
  localparam logic [7:0] TX_STATUS_CONTROL_OFF = 8'h00;
  localparam logic [7:0] RX_STATUS_CONTROL_OFF = 8'h04;
  localparam logic [7:0] BAUD_CONTROL_OFF      = 8'h08;
  localparam logic [7:0] TRANSMIT_BUFFER_OFF   = 8'h0c;
  localparam logic [7:0] RECEIVE_BUFFER_OFF    = 8'h10;
  localparam logic [7:0] BAUD_DIVISOR_HIGH_OFF = 8'h14;
  localparam logic [7:0] BAUD_DIVISOR_LOW_OFF  = 8'h18;
  localparam logic [7:0] IRQ_FLAGS_OFF         = 8'h1c;

  // tx_status_control fields
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int NINTH_BIT_TX_ENABLE_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT     = 5;
  localparam int SYNC_MODE_BIT           = 4;
  localparam int SEND_BREAK_BIT          = 3;
  localparam int SHIFT_REG_EMPTY_BIT     = 1;
  localparam int NINTH_BIT_TX_VALUE_BIT  = 0;
  // rx_status_control fields
  localparam int PORT_ENABLE_BIT         = 7;
  localparam int CONT_RECEIVE_BIT        = 4;
  // baud_control fields
  localparam int RECEIVE_IDLE_STATUS_BIT = 6;
  localparam int CLOCK_POLARITY_BIT      = 4;
  localparam int WIDE_BAUD_SELECT_BIT    = 3;
  localparam int WAKE_ENABLE_BIT         = 1;
  // irq_flags fields
  localparam int RECEIVE_IRQ_FLAG_BIT    = 0;
  localparam int TRANSMIT_IRQ_FLAG_BIT   = 1;

  // reset values
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] DIVISOR_RESET   = 8'h00;

  // frame shapes
  localparam logic [3:0] ASYNC_BITS_8    = 4'ha;
  localparam logic [3:0] ASYNC_BITS_9    = 4'hb;
  localparam logic [3:0] BREAK_BITS      = 4'he;
  localparam logic [3:0] SYNC_BITS_8     = 4'h8;
  localparam logic [3:0] SYNC_BITS_9     = 4'h9;
  localparam logic [13:0] BREAK_FRAME    = 14'h2000;
  localparam logic [3:0] RX_STOP_SLOT    = 4'h9;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC  = 3'b100
  } tx_state_e;

endpackage : serial_port_pkg

// ===== test/remote_serial_node.sv
// partner: remote node driving the receive line and decoding our frames
`timescale 1ns/1ns
module remote_serial_node (
  input  wire logic pclk,
  input  wire logic line_out,
  input  wire logic line_oe,
  input  wire logic sck,
  input  wire logic sck_oe,
  output logic      line_in
);
  int          bit_cycles = 8;
  logic        pol = 1'b0;
  logic        lclk = 1'b0;
  logic        lrun = 1'b0;
  logic        sck_q = 1'b0;
  logic [13:0] v;
  logic [13:0] got_q[$];
  logic        bit_q[$];
  //////////////////////////////////////////////////////////////////////////
  initial line_in = 1'b1;
  // link clock stands still outside frames
  always #32 lclk = lrun & ~lclk;

  // lsb first, one bit per link period; pulled high once released
  task automatic send_bits(input logic [15:0] b, input int n);
    lrun = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge lclk);
      line_in = b[i];
    end
    @(posedge lclk);
    line_in = 1'b1;
    lrun = 1'b0;
  endtask : send_bits

  // always takes 14 samples: short frames pad with idle ones
  always begin
    @(posedge pclk);
    if (line_oe && !line_out && !sck_oe) begin
      repeat (bit_cycles / 2) @(posedge pclk);
      for (int i = 0; i < 14; i++) begin
        v[i] = line_out;
        if (i < 13) repeat (bit_cycles) @(posedge pclk);
      end
      got_q.push_back(v);
    end
  end

  // sync bit taken as the clock leaves its idle level: data moves together
  // with the return to idle, so only the leaving edge sits mid-bit
  always @(posedge pclk) begin
    sck_q <= sck;
    if (sck_oe && sck != sck_q && sck != pol) bit_q.push_back(line_out);
  end
endmodule : remote_serial_node

// ===== test/serial_break_wake_sync_master_tx_bench.sv
// bench: registers, async and break transmit, wake, sync master transmit
`timescale 1ns/1ns
module serial_break_wake_sync_master_tx_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_v;
  logic        pready, pslverr, err_v, data_line_in, data_line_out;
  logic        data_line_oe, shift_clock_line_out, shift_clock_line_oe;
  logic        receive_irq_flag, transmit_irq_flag;
  logic [7:0]  d;
  logic [13:0] e;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          exp_q[$];

  always #4 pclk = ~pclk;

  serial_break_wake_sync_master_tx dut (
    .pclk, .presetn, .clk_en, .sleep_mode, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .data_line_in, .data_line_out, .data_line_oe, .shift_clock_line_out,
    .shift_clock_line_oe, .receive_irq_flag, .transmit_irq_flag
  );
  remote_serial_node rn (
    .pclk, .line_out(data_line_out), .line_oe(data_line_oe),
    .sck(shift_clock_line_out), .sck_oe(shift_clock_line_oe),
    .line_in(data_line_in)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // entered right after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd_v  = prdata;
    err_v = pslverr;
    if (n >= 64) n_fail++;
    if (n >= 64) give_verdict();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // 0: decoded frames, 1: sync bits, 2: receive flag
  task automatic wait_for(input int w, input int cnt);
    int n;
    n = 0;
    while (n < 4000 && (w == 0 ? rn.got_q.size() : w == 1 ?
           rn.bit_q.size() : int'(receive_irq_flag === 1'b1)) < cnt) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) n_fail++;
    if (n >= 4000) give_verdict();
  endtask : wait_for

  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h4a0b37a0));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // status bits masked: they report live state, not stored values
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", 32'h0, rd_v & ~32'h42);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err_v});
    $display("test registers done");
    apb(1'b1, 8'h18, 32'h7);
    apb(1'b1, 8'h04, 32'h80);
    // clock enable low: the write must wait in its access phase
    clk_en <= 1'b0;
    fork
      apb(1'b1, 8'h14, 32'h5a);
      begin
        repeat (5) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    apb(1'b0, 8'h14, 32'h0);
    chk("write held by enable", 32'h5a, rd_v);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h00, k ? 32'h61 : 32'h20);
      chk("tx flag on enable", 32'h1, {31'h0, transmit_irq_flag});
      d = 8'($urandom);
      e = 14'(({6'h0, d} << 1) | (k << 9) | (14'h3fff << (9 + k)));
      exp_q.push_back(int'(e));
      apb(1'b1, 8'h0c, {24'h0, d});
      apb(1'b0, 8'h00, 32'h0);
      chk("empty while busy", 32'h0, {31'h0, rd_v[1]});
      wait_for(0, 1);
      chk("async frame", exp_q.pop_front(), 32'(rn.got_q.pop_front()));
      apb(1'b0, 8'h00, 32'h0);
      chk("empty when done", 32'h1, {31'h0, rd_v[1]});
    end
    $display("test async transmit done");
    apb(1'b1, 8'h00, 32'h28);
    apb(1'b1, 8'h0c, 32'($urandom) & 32'hff);
    apb(1'b1, 8'h0c, 32'h55);
    chk("flag while queued", 32'h0, {31'h0, transmit_irq_flag});
    apb(1'b0, 8'h00, 32'h0);
    chk("break busy", 32'h08, rd_v & 32'h0a);
    wait_for(0, 2);
    chk("break frame", 32'h2000, 32'(rn.got_q.pop_front()));
    chk("sync char", 32'h3eaa, 32'(rn.got_q.pop_front()));
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("break bit after", 32'h02, rd_v & 32'h0a);
    chk("tx flag after", 32'h1, {31'h0, transmit_irq_flag});
    $display("test break done");
    apb(1'b1, 8'h04, 32'h90);
    apb(1'b0, 8'h08, 32'h0);
    chk("receive idle", 32'h40, rd_v & 32'h40);
    apb(1'b1, 8'h08, 32'h02);
    sleep_mode <= 1'b1;
    fork
      rn.send_bits(16'h0, 13);
      begin
        repeat (30) @(posedge pclk);
        chk("wake flag", 32'h1, {31'h0, receive_irq_flag});
        apb(1'b0, 8'h08, 32'h0);
        chk("wake still armed", 32'h02, rd_v & 32'h02);
      end
    join
    repeat (10) @(posedge pclk);
    sleep_mode <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk("wake self clear", 32'h0, rd_v & 32'h02);
    apb(1'b0, 8'h10, 32'h0);
    chk("flag after read", 32'h0, {31'h0, receive_irq_flag});
    d = 8'($urandom);
    rn.send_bits({6'h3f, 1'b1, d, 1'b0}, 10);
    wait_for(2, 1);
    apb(1'b0, 8'h10, 32'h0);
    chk("byte after break", {24'h0, d}, rd_v);
    // break taken as a zero byte with the bit time near thirteen ninths of the link's
    apb(1'b1, 8'h18, 32'hb);
    rn.send_bits(16'h0, 13);
    wait_for(2, 1);
    apb(1'b0, 8'h10, 32'h0);
    chk("break as zero byte", 32'h0, rd_v);
    apb(1'b1, 8'h18, 32'h7);
    $display("test wake done");
    for (int k = 1; k >= 0; k--) begin
      rn.pol = k[0];
      apb(1'b1, 8'h08, k ? 32'h10 : 32'h0);
      apb(1'b1, 8'h00, 32'hb0);
      chk("clock idle", {31'h0, k[0]}, {31'h0, shift_clock_line_out});
      chk("clock driven", 32'h1, {31'h0, shift_clock_line_oe});
      rn.bit_q.delete();
      d = 8'($urandom);
      apb(1'b1, 8'h0c, {24'h0, d});
      wait_for(1, 8);
      e = 14'h0;
      for (int i = 0; i < 8; i++) e[i] = rn.bit_q.pop_front();
      chk("sync word", {24'h0, d}, 32'(e));
    end
    $display("test sync master done");
    give_verdict();
  end
endmodule : serial_break_wake_sync_master_tx_bench

// ===== test/serial_break_wake_sync_master_tx_checker.sv
// checker: port-level assertions for the serial port block
`timescale 1ns/1ns
module serial_break_wake_sync_master_tx_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       clk_en,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       data_line_out,
  input wire logic       data_line_oe,
  input wire logic       shift_clock_line_out,
  input wire logic       shift_clock_line_oe,
  input wire logic       receive_irq_flag,
  input wire logic       transmit_irq_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  logic shifting;
  assign acc      = psel && penable && clk_en;
  assign wr       = acc && pwrite;
  assign shifting = shift_clock_line_oe && data_line_oe;
  //////////////////////////////////////////////////////////////////////////
  a_unmapped_err: assert property (acc && paddr > 8'h1c |-> pslverr)
    else $error("unmapped access without error");
  a_buffer_write_flag: assert property (
    wr && paddr == 8'h0c |=> !transmit_irq_flag)
    else $error("transmit flag high after buffer write");
  a_tx_flag_fall: assert property (
    $fell(transmit_irq_flag) |-> $past(wr) &&
    ($past(paddr) == 8'h0c || $past(paddr) == 8'h00))
    else $error("transmit flag cleared without a write");
  a_rx_flag_hold: assert property (
    $fell(receive_irq_flag) |-> $past(acc) && !$past(pwrite) &&
    $past(paddr) == 8'h10)
    else $error("receive flag cleared without a read");
  a_read_clears: assert property (
    acc && !pwrite && paddr == 8'h10 |=> !receive_irq_flag)
    else $error("receive flag survives a buffer read");
  a_sync_data_hold: assert property (
    shifting && $past(data_line_oe) && $changed(data_line_out)
    |-> $changed(shift_clock_line_out))
    else $error("sync data moved inside a clock period");
  a_clock_idle_still: assert property (
    shift_clock_line_oe && !data_line_oe && !$past(data_line_oe) &&
    !$past(wr) |-> $stable(shift_clock_line_out))
    else $error("shift clock moved while idle");
  a_half_duplex: assert property (
    shifting |=> !$rose(receive_irq_flag))
    else $error("reception during sync transmit");
  c_buffer_write: cover property (wr && paddr == 8'h0c);
  c_rx_flag: cover property ($rose(receive_irq_flag));
  c_sync_word: cover property (shifting ##1 !data_line_oe);
endmodule : serial_break_wake_sync_master_tx_checker

bind serial_break_wake_sync_master_tx
  serial_break_wake_sync_master_tx_checker checker_i (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pslverr,
    .data_line_out, .data_line_oe, .shift_clock_line_out,
    .shift_clock_line_oe, .receive_irq_flag, .transmit_irq_flag
  );
